// ---- prc_pkg.sv ----
// Shared constants and latency function for the pseudo-static RAM configuration link
package prc_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned INIT_US = 150;
  localparam int unsigned INIT_CYCLES = INIT_US * CLK_MHZ;
  localparam int unsigned AW = 22;
  localparam int unsigned DW = 16;
  // Register select field on the address bits
  localparam int unsigned SEL_LO = 18;
  localparam logic [1:0] SEL_REFRESH = 2'h0;
  localparam logic [1:0] SEL_IDENT = 2'h1;
  localparam logic [1:0] SEL_BURST = 2'h2;
  // Refresh register layout
  localparam logic [21:0] REFRESH_RESET = 22'h000010;
  localparam logic [21:0] REFRESH_WMASK = 22'h000097;
  localparam int unsigned PAGE_BIT = 7;
  localparam int unsigned PDOWN_BIT = 4;
  localparam int unsigned REGION_LO = 0;
  // Burst register layout
  localparam logic [15:0] BURST_RESET = 16'h9D1F;
  localparam int unsigned MODE_BIT = 15;
  localparam int unsigned FIXED_BIT = 14;
  localparam int unsigned LAT_LO = 11;
  localparam int unsigned DRV_BIT = 4;
  localparam logic [2:0] LAT_DEFAULT = 3'h3;
  localparam logic [2:0] LAT_CODE8 = 3'h0;
  localparam logic [3:0] LAT_EIGHT = 4'h8;
  // Partial-array codes and region bounds in words
  localparam logic [2:0] REGION_NONE = 3'h4;
  localparam logic [21:0] TOP_WORD = 22'h3FFFFF;
  localparam logic [21:0] HALF_WORD = 22'h1FFFFF;
  localparam logic [21:0] QUART_WORD = 22'h0FFFFF;
  localparam logic [21:0] EIGHT_WORD = 22'h07FFFF;
  localparam logic [21:0] TOP_HALF = 22'h200000;
  localparam logic [21:0] TOP_QUART = 22'h300000;
  localparam logic [21:0] TOP_EIGHT = 22'h380000;
  // Host APB register offsets; the host does not decode REG_REGION and answers it with pslverr
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_LATENCY = 8'h14;
  localparam logic [7:0] REG_REGION = 8'h18;
  // Host control commands
  localparam logic [2:0] CMD_CFG_WR = 3'h1;
  localparam logic [2:0] CMD_CFG_RD = 3'h2;
  localparam logic [2:0] CMD_BURST = 3'h3;
  localparam logic [2:0] CMD_SLEEP = 3'h4;
  localparam logic [2:0] CMD_WAKE = 3'h5;
  localparam logic [15:0] IDENT_VALUE = 16'h1234; // Arbitrary value

  // Latency count for a code; zero marks a reserved code
  function automatic logic [3:0] prc_lat(input logic fixed,
                                         input logic [2:0] code);
    logic [3:0] n;
    n = 4'h0;
    if (fixed) begin
      if (code == LAT_CODE8) begin
        n = LAT_EIGHT;
      end else if (code >= 3'h2 && code <= 3'h6) begin
        n = {1'b0, code};
      end
    end else if (code >= 3'h2 && code <= 3'h4) begin
      n = {1'b0, code};
    end
    return n;
  endfunction
endpackage

// ---- prc_if.sv ----
// Pin-level link between controller and memory configuration logic
`timescale 1ns/10ps
interface prc_if;
  logic ce_n;
  logic register_enable_pin;
  logic we_n;
  logic adv_n;
  logic [21:0] addr;
  logic [15:0] dq_host;
  logic [15:0] dq_dev;
  logic dq_dev_oe;
  logic hold_off;
  modport host (
    output ce_n, register_enable_pin, we_n, adv_n, addr, dq_host,
    input dq_dev, dq_dev_oe, hold_off
  );
  modport dev (
    input ce_n, register_enable_pin, we_n, adv_n, addr, dq_host,
    output dq_dev, dq_dev_oe, hold_off
  );
endinterface

// ---- prc_sync.sv ----
// Three-stage input synchroniser with agreement of the last two stages
`timescale 1ns/10ps
module prc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= INIT;
    end else if (s2 == s3) begin
      q <= s3;
    end
  end
endmodule

// ---- prc_device.sv ----
// Memory-side configuration registers, latency and deep power-down logic
`timescale 1ns/10ps
module prc_device
  import prc_pkg::*;
#(
  parameter int unsigned INIT_CYC = INIT_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Memory pins
  prc_if.dev mem,
  // Core side
  input wire logic refresh_collision,
  output logic [21:0] refresh_lo,
  output logic [21:0] refresh_hi,
  output logic refresh_on,
  output logic powered_down,
  output logic init_busy,
  output logic page_mode,
  output logic sync_mode,
  output logic data_phase
);
  import prc_pkg::*;
  typedef enum logic [1:0] {
    PRC_IDLE,
    PRC_LATENCY,
    PRC_DATA
  } prc_burst_e;

  logic [15:0] burst_configuration;
  logic [21:0] refresh_configuration;
  logic [21:0] sa;
  logic [15:0] sdq;
  logic [3:0] sctl;
  logic ce_n_s;
  logic reg_en_s;
  logic next_powered_down;
  logic we_n_s;
  logic adv_n_s;
  logic ce_n_d;
  logic cfg_wr;
  logic [1:0] sel;
  logic [3:0] lat_n;
  logic [4:0] lat_cnt;
  logic [4:0] lat_target;
  logic [$clog2(INIT_CYC+1)-1:0] init_cnt;
  prc_burst_e state;

  prc_sync #(.W(AW)) u_sync_a (
    .pclk(pclk), .presetn(presetn), .d(mem.addr), .q(sa));
  prc_sync #(.W(DW)) u_sync_d (
    .pclk(pclk), .presetn(presetn), .d(mem.dq_host), .q(sdq));
  prc_sync #(.W(4), .INIT(4'hF)) u_sync_c (
    .pclk(pclk), .presetn(presetn),
    .d({mem.ce_n, mem.register_enable_pin, mem.we_n, mem.adv_n}),
    .q(sctl));

  assign {ce_n_s, reg_en_s, we_n_s, adv_n_s} = sctl;
  // Select decode
  assign sel = sa[SEL_LO+:2];
  assign cfg_wr = !ce_n_s && ce_n_d == 1'b0 && reg_en_s && !we_n_s
    && !adv_n_s && !powered_down;
  assign lat_n = prc_lat(burst_configuration[FIXED_BIT],
                         burst_configuration[LAT_LO+:3]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_n_d <= 1'b1;
    end else begin
      ce_n_d <= ce_n_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_configuration <= REFRESH_RESET;
    end else if (powered_down && !ce_n_s) begin
      refresh_configuration[PDOWN_BIT] <= 1'b1;
    end else if (cfg_wr && sel == SEL_REFRESH) begin
      refresh_configuration <= {6'h00, sa[15:0]} & REFRESH_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_configuration <= BURST_RESET;
    end else if (powered_down && !ce_n_s) begin
      burst_configuration[DRV_BIT] <= BURST_RESET[DRV_BIT];
    end else if (cfg_wr && sel == SEL_BURST) begin
      burst_configuration <= sa[15:0];
    end
  end

  always_comb begin
    next_powered_down = powered_down;
    if (powered_down) begin
      next_powered_down = ce_n_s;
    end else if (ce_n_s && !ce_n_d
                 && !refresh_configuration[PDOWN_BIT]) begin
      next_powered_down = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powered_down <= 1'b0;
    end else begin
      powered_down <= next_powered_down;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt <= '0;
      init_busy <= 1'b0;
    end else if (powered_down && !ce_n_s) begin
      init_cnt <= ($clog2(INIT_CYC+1))'(INIT_CYC - 1);
      init_busy <= 1'b1;
    end else if (init_cnt != '0) begin
      init_cnt <= init_cnt - 1'b1;
    end else begin
      init_busy <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_lo <= '0;
      refresh_hi <= TOP_WORD;
      refresh_on <= 1'b1;
      page_mode <= 1'b0;
      sync_mode <= 1'b0;
    end else begin
      page_mode <= refresh_configuration[PAGE_BIT];
      sync_mode <= !burst_configuration[MODE_BIT];
      refresh_on <= !next_powered_down
        && refresh_configuration[REGION_LO+:3] != REGION_NONE;
      unique case (refresh_configuration[REGION_LO+:3])
        3'h1: begin refresh_lo <= '0; refresh_hi <= HALF_WORD; end
        3'h2: begin refresh_lo <= '0; refresh_hi <= QUART_WORD; end
        3'h3: begin refresh_lo <= '0; refresh_hi <= EIGHT_WORD; end
        3'h5: begin refresh_lo <= TOP_HALF; refresh_hi <= TOP_WORD; end
        3'h6: begin refresh_lo <= TOP_QUART; refresh_hi <= TOP_WORD; end
        3'h7: begin refresh_lo <= TOP_EIGHT; refresh_hi <= TOP_WORD; end
        3'h4: begin refresh_lo <= '0; refresh_hi <= '0; end
        default: begin refresh_lo <= '0; refresh_hi <= TOP_WORD; end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PRC_IDLE;
      lat_cnt <= '0;
      lat_target <= '0;
      mem.hold_off <= 1'b0;
      data_phase <= 1'b0;
    end else begin
      unique case (state)
        PRC_IDLE: begin
          data_phase <= 1'b0;
          if (!ce_n_s && !adv_n_s && !reg_en_s && !powered_down
              && sync_mode && lat_n != 4'h0) begin
            state <= PRC_LATENCY;
            lat_cnt <= 5'h01;
            if (burst_configuration[FIXED_BIT] || !refresh_collision) begin
              lat_target <= {1'b0, lat_n};
            end else begin
              lat_target <= {lat_n, 1'b0};
            end
            mem.hold_off <= !burst_configuration[FIXED_BIT]
              && refresh_collision;
          end
        end
        PRC_LATENCY: begin
          lat_cnt <= lat_cnt + 1'b1;
          if (lat_cnt == lat_target) begin
            state <= PRC_DATA;
            mem.hold_off <= 1'b0;
            data_phase <= 1'b1;
          end
        end
        PRC_DATA: begin
          if (ce_n_s) begin
            state <= PRC_IDLE;
            data_phase <= 1'b0;
          end
        end
      endcase
    end
  end

  // Register read-back drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem.dq_dev <= '0;
      mem.dq_dev_oe <= 1'b0;
    end else begin
      mem.dq_dev_oe <= !ce_n_s && reg_en_s && we_n_s && !powered_down;
      unique case (sel)
        SEL_REFRESH: mem.dq_dev <= refresh_configuration[15:0];
        SEL_IDENT: mem.dq_dev <= IDENT_VALUE;
        SEL_BURST: mem.dq_dev <= burst_configuration;
        default: mem.dq_dev <= '0;
      endcase
    end
  end
endmodule

// ---- prc_host.sv ----
// Controller end: APB registers drive configuration and power sequences
`timescale 1ns/10ps
module prc_host
  import prc_pkg::*;
#(
  parameter int unsigned INIT_CYC = INIT_CYCLES,
  parameter int unsigned STEP = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory pins
  prc_if.host mem
);
  typedef enum logic [1:0] {
    PRH_IDLE,
    PRH_DRIVE,
    PRH_WAIT
  } prh_state_e;

  logic [21:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [2:0] cmd;
  logic busy;
  logic [$clog2(STEP+1)-1:0] step_cnt;
  logic [$clog2(INIT_CYC+1)-1:0] wait_cnt;
  logic [2:0] lat_code;
  logic [15:0] dq_s;
  logic hold_s;
  prh_state_e state;

  prc_sync #(.W(DW)) u_sync_dq (
    .pclk(pclk), .presetn(presetn), .d(mem.dq_dev), .q(dq_s));
  prc_sync #(.W(1)) u_sync_h (
    .pclk(pclk), .presetn(presetn), .d(mem.hold_off), .q(hold_s));

  // APB register access, one wait-free answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= '0;
      wdata_reg <= '0;
      lat_code <= LAT_DEFAULT;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= '0;
        unique case (paddr)
          REG_ADDR: if (pwrite) addr_reg <= pwdata[21:0];
                    else prdata <= {10'h000, addr_reg};
          REG_WDATA: if (pwrite) wdata_reg <= pwdata[15:0];
                     else prdata <= {16'h0000, wdata_reg};
          REG_STATUS: prdata <= {29'h0, hold_s, mem.ce_n, busy};
          REG_RDATA: prdata <= {16'h0000, rdata_reg};
          REG_LATENCY: if (pwrite) lat_code <= pwdata[2:0];
                       else prdata <= {29'h0, lat_code};
          REG_CTRL: ;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  assign cmd = (psel && !penable && pwrite && paddr == REG_CTRL && !busy)
    ? pwdata[2:0] : 3'h0;

  // Pin sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PRH_IDLE;
      busy <= 1'b0;
      step_cnt <= '0;
      wait_cnt <= '0;
      rdata_reg <= '0;
      mem.ce_n <= 1'b1;
      mem.register_enable_pin <= 1'b0;
      mem.we_n <= 1'b1;
      mem.adv_n <= 1'b1;
      mem.addr <= '0;
      mem.dq_host <= '0;
    end else begin
      unique case (state)
        PRH_IDLE: begin
          step_cnt <= ($clog2(STEP+1))'(STEP);
          if (cmd != 3'h0) begin
            busy <= 1'b1;
            state <= PRH_DRIVE;
            mem.addr <= addr_reg;
            mem.dq_host <= wdata_reg;
            mem.ce_n <= (cmd == CMD_SLEEP);
            mem.register_enable_pin <= cmd == CMD_CFG_WR
              || cmd == CMD_CFG_RD;
            mem.we_n <= cmd != CMD_CFG_WR;
            mem.adv_n <= cmd == CMD_SLEEP || cmd == CMD_WAKE;
            wait_cnt <= cmd == CMD_WAKE
              ? ($clog2(INIT_CYC+1))'(INIT_CYC) : '0;
          end
        end
        PRH_DRIVE: begin
          step_cnt <= step_cnt - 1'b1;
          if (step_cnt == '0) begin
            rdata_reg <= dq_s;
            mem.ce_n <= 1'b1;
            mem.we_n <= 1'b1;
            mem.adv_n <= 1'b1;
            mem.register_enable_pin <= 1'b0;
            state <= PRH_WAIT;
          end
        end
        PRH_WAIT: begin
          if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - 1'b1;
          end else if (!hold_s) begin
            busy <= 1'b0;
            state <= PRH_IDLE;
          end
        end
        default: state <= PRH_IDLE;
      endcase
    end
  end
endmodule

// ---- prc_link_checker.sv ----
// Checker on the link pins and device status between the two ends
`timescale 1ns/10ps
module prc_link_checker #(
  parameter int unsigned INIT_CYC = 20
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link pins
  input wire logic ce_n,
  input wire logic register_enable_pin,
  input wire logic dq_dev_oe,
  input wire logic hold_off,
  // Device status
  input wire logic [21:0] refresh_lo,
  input wire logic [21:0] refresh_hi,
  input wire logic refresh_on,
  input wire logic powered_down,
  input wire logic init_busy,
  input wire logic sync_mode,
  input wire logic data_phase
);
  import prc_pkg::*;
  logic [15:0] icnt;
  // Length of the current init period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icnt <= '0;
    end else if (init_busy) begin
      icnt <= icnt + 16'h1;
    end else begin
      icnt <= '0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wake_s;
    !ce_n ##[0:2] init_busy;
  endsequence
  sequence start_s;
    !ce_n && !register_enable_pin && sync_mode;
  endsequence
  pd_entry_a: assert property (
    $rose(powered_down) |-> ce_n) else $error("power-down without ce_n high");
  pd_norefresh_a: assert property (
    powered_down |-> !refresh_on) else $error("refresh during power-down");
  wake_init_a: assert property (
    $fell(powered_down) |-> wake_s) else $error("wake without init period");
  init_len_a: assert property (
    $fell(init_busy) |-> icnt == INIT_CYC) else $error("init period length");
  init_quiet_a: assert property (
    init_busy |-> !data_phase) else $error("data during init period");
  hold_gap_a: assert property (
    hold_off |-> !data_phase) else $error("data while hold-off high");
  data_start_a: assert property (
    $rose(data_phase) |-> start_s) else $error("data phase without burst");
  read_oe_a: assert property (
    $rose(dq_dev_oe) |-> !ce_n) else $error("data driven while deselected");
  region_a: assert property (
    refresh_on |-> refresh_lo <= refresh_hi &&
    (refresh_lo == '0 || refresh_hi == TOP_WORD)) else $error("region bounds");
endmodule

// ---- tb_psram_latency_refresh_config.sv ----
// Testbench joining host and device ends, driven over APB
`timescale 1ns/10ps
module tb_psram_latency_refresh_config;
  import prc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic refresh_collision = 1'b0;
  logic [21:0] refresh_lo;
  logic [21:0] refresh_hi;
  logic refresh_on;
  logic powered_down;
  logic init_busy;
  logic page_mode;
  logic sync_mode;
  logic data_phase;
  int bad_count = 0;
  int compares = 0;
  int cnt = 0;
  int lat = 0;
  int base;
  int vl;
  int n;
  logic [31:0] rd;
  logic err;
  logic saw;
  logic ho;
  logic [2:0] fc [6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0};
  int fn [6] = '{2, 3, 4, 5, 6, 8};
  logic [21:0] plo [8] = '{22'h0, 22'h0, 22'h0, 22'h0, 22'h0, 22'h200000,
    22'h300000, 22'h380000};
  logic [21:0] phi [8] = '{22'h3FFFFF, 22'h1FFFFF, 22'h0FFFFF, 22'h07FFFF,
    22'h0, 22'h3FFFFF, 22'h3FFFFF, 22'h3FFFFF};
  always #12.5 pclk = ~pclk;
  prc_if bus();
  prc_host #(.INIT_CYC(20), .STEP(24)) prc_host_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem(bus));
  prc_device #(.INIT_CYC(20)) prc_device_i (.pclk(pclk), .presetn(presetn),
    .mem(bus), .refresh_collision(refresh_collision),
    .refresh_lo(refresh_lo), .refresh_hi(refresh_hi),
    .refresh_on(refresh_on), .powered_down(powered_down),
    .init_busy(init_busy), .page_mode(page_mode), .sync_mode(sync_mode),
    .data_phase(data_phase));
  prc_link_checker #(.INIT_CYC(20)) prc_link_checker_i (.pclk(pclk),
    .presetn(presetn), .ce_n(bus.ce_n),
    .register_enable_pin(bus.register_enable_pin),
    .dq_dev_oe(bus.dq_dev_oe), .hold_off(bus.hold_off),
    .refresh_lo(refresh_lo), .refresh_hi(refresh_hi),
    .refresh_on(refresh_on), .powered_down(powered_down),
    .init_busy(init_busy), .sync_mode(sync_mode), .data_phase(data_phase));
  // Cycles from chip select to data, frozen in the data phase
  always @(posedge pclk) begin
    if (bus.ce_n !== 1'b0) begin
      cnt <= 0;
    end else if (data_phase !== 1'b1) begin
      cnt <= cnt + 1;
    end
    if (data_phase === 1'b1 && bus.ce_n === 1'b0) begin
      lat <= cnt;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      bad_count++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle();
    int k;
    repeat (2) @(posedge pclk);
    k = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 200);
    if (rd[0] !== 1'b0) begin
      bad_count++;
    end
  endtask
  task automatic cfg_wr(input logic [1:0] s, input logic [15:0] v);
    apb(1'b1, REG_ADDR, 32'({s, 2'b00, v}));
    apb(1'b1, REG_CTRL, 32'(CMD_CFG_WR));
    wait_idle();
  endtask
  task automatic cfg_rd(input logic [1:0] s);
    apb(1'b1, REG_ADDR, 32'({s, 2'b00, 16'h0000}));
    apb(1'b1, REG_CTRL, 32'(CMD_CFG_RD));
    wait_idle();
    apb(1'b0, REG_RDATA, 32'h0);
    rd = rd & 32'h0000FFFF;
  endtask
  task automatic burst(input logic f, input logic [2:0] c, input logic col);
    cfg_wr(SEL_BURST, {1'b0, f, c, 11'h51F});
    refresh_collision <= col;
    saw = 1'b0;
    ho = 1'b0;
    apb(1'b1, REG_CTRL, 32'(CMD_BURST));
    repeat (60) begin
      @(posedge pclk);
      saw = saw | (data_phase === 1'b1);
      ho = ho | (bus.hold_off === 1'b1);
    end
    wait_idle();
    refresh_collision <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("page_mode", 32'h0, {31'h0, page_mode});
    chk("sync_mode", 32'h0, {31'h0, sync_mode});
    cfg_rd(SEL_REFRESH);
    chk("refresh_reg", 32'h0010, rd);
    cfg_rd(SEL_BURST);
    chk("burst_reg", 32'h9D1F, rd);
    cfg_rd(SEL_IDENT);
    chk("ident_reg", 32'(IDENT_VALUE), rd);
    apb(1'b0, REG_REGION, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b0, REG_LATENCY, 32'h0);
    chk("latency_reset", 32'(LAT_DEFAULT), rd);
    apb(1'b1, REG_LATENCY, 32'(LAT_CODE8));
    apb(1'b0, REG_LATENCY, 32'h0);
    chk("latency_code", 32'(LAT_CODE8), rd);
    chk("mapped_err", 32'h0, {31'h0, err});
    $display("Test reset done");
    cfg_wr(SEL_REFRESH, 16'hFFFF);
    cfg_rd(SEL_REFRESH);
    chk("refresh_masked", 32'h0097, rd);
    chk("page_mode", 32'h1, {31'h0, page_mode});
    $display("Test reserved bits done");
    for (int p = 0; p < 8; p++) begin
      cfg_wr(SEL_REFRESH, {13'h0002, 3'(p)});
      chk("refresh_on", 32'(p != 4), {31'h0, refresh_on});
      if (p != 4) begin
        chk("refresh_lo", 32'(plo[p]), 32'(refresh_lo));
        chk("refresh_hi", 32'(phi[p]), 32'(refresh_hi));
      end
    end
    $display("Test partial refresh done");
    apb(1'b1, REG_CTRL, 32'(CMD_SLEEP));
    repeat (30) @(posedge pclk);
    chk("no_power_down", 32'h0, {31'h0, powered_down});
    apb(1'b1, REG_CTRL, 32'(CMD_WAKE));
    wait_idle();
    repeat (40) @(posedge pclk);
    cfg_wr(SEL_BURST, 16'h9D0F);
    cfg_wr(SEL_REFRESH, 16'h0082);
    apb(1'b1, REG_CTRL, 32'(CMD_SLEEP));
    wait_idle();
    n = 0;
    while (powered_down !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("power_down", 32'h1, {31'h0, powered_down});
    chk("refresh_off", 32'h0, {31'h0, refresh_on});
    apb(1'b1, REG_CTRL, 32'(CMD_WAKE));
    n = 0;
    while (init_busy !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (init_busy === 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("init_len", 32'd20, 32'(n));
    chk("woken", 32'h0, {31'h0, powered_down});
    wait_idle();
    cfg_rd(SEL_REFRESH);
    chk("refresh_kept", 32'h0092, rd);
    cfg_rd(SEL_BURST);
    chk("burst_kept", 32'h9D1F, rd);
    $display("Test power down done");
    for (int i = 0; i < 6; i++) begin
      burst(1'b1, fc[i], 1'b0);
      if (i == 0) begin
        base = lat;
      end
      chk("fixed_lat", 32'(fn[i] - 2), 32'(lat - base));
    end
    chk("sync_mode", 32'h1, {31'h0, sync_mode});
    burst(1'b1, 3'h3, 1'b1);
    chk("fixed_col", 32'h1, 32'(lat - base));
    for (int i = 0; i < 3; i++) begin
      burst(1'b0, fc[i], 1'b0);
      if (i == 0) begin
        base = lat;
      end
      chk("var_lat", 32'(fn[i] - 2), 32'(lat - base));
      chk("no_hold_off", 32'h0, {31'h0, ho});
      vl = lat;
      burst(1'b0, fc[i], 1'b1);
      chk("var_col", 32'(fn[i]), 32'(lat - vl));
      chk("hold_off", 32'h1, {31'h0, ho});
    end
    burst(1'b1, 3'h7, 1'b0);
    chk("fixed_rsvd", 32'h0, {31'h0, saw});
    burst(1'b0, 3'h5, 1'b0);
    chk("var_rsvd", 32'h0, {31'h0, saw});
    $display("Test latency done");
    give_verdict();
  end
endmodule
